// file: rsrb_regs.svh
// Purpose: Offsets, field positions and constants of the radio status register bank
// Assumes: Included by the package; the bank module uses its macros
// Notes:   Offsets are the 6-bit register addresses of the configuration port
`ifndef RSRB_REGS_SVH
`define RSRB_REGS_SVH

`define RSRB_ADDR_W          6
`define RSRB_OFF_PKT_STATUS  6'h38
`define RSRB_OFF_VCO_DAC     6'h39
`define RSRB_OFF_TX_COUNT    6'h3a
`define RSRB_OFF_RX_COUNT    6'h3b
`define RSRB_OFF_RC_HIGH     6'h3c
`define RSRB_OFF_RC_LOW      6'h3d
`define RSRB_OFF_IRQ_STATUS  6'h3e
`define RSRB_OFF_IRQ_MASK    6'h3f

`define RSRB_BIT_CRC_MATCH   7
`define RSRB_BIT_CARRIER     6
`define RSRB_BIT_PQ_REACHED  5
`define RSRB_BIT_CHAN_CLEAR  4
`define RSRB_BIT_FRAME_START 3
`define RSRB_BIT_PIN_TWO     2
`define RSRB_BIT_PIN_ZERO    0
`define RSRB_BIT_BUF_FLAG    7

`define RSRB_STATE_RX        5'h0d
`define RSRB_SEL_LOCK        6'h0a
`define RSRB_RST_BYTE        8'h00
`define RSRB_RST_MASK        4'h0

`define RSRB_IRQ_CRC         0
`define RSRB_IRQ_FRAME       1
`define RSRB_IRQ_TX_UNDER    2
`define RSRB_IRQ_RX_OVER     3

`endif

// file: rsrb_pkg.sv
// Purpose: Types of the radio status register bank
// Assumes: rsrb_regs.svh gives the constants
// Notes:   Radio events arrive grouped in one struct
package rsrb_pkg;

   `include "rsrb_regs.svh"

   // Radio control state codes used by the bank
   typedef enum logic [4:0] {
      RSRB_ST_SLEEP    = 5'h00,
      RSRB_ST_IDLE     = 5'h01,
      RSRB_ST_RX       = 5'h0d,
      RSRB_ST_RX_END   = 5'h0e,
      RSRB_ST_RX_RST   = 5'h0f,
      RSRB_ST_RX_OVER  = 5'h11,
      RSRB_ST_TX       = 5'h13,
      RSRB_ST_TX_END   = 5'h14,
      RSRB_ST_TX_UNDER = 5'h16
   } rsrb_state_type;

   typedef struct packed {
      logic crcDone;      // CRC check finished this cycle
      logic crcPass;      // Result of that check
      logic carrierSense; // Carrier sense level
      logic chanClear;    // Channel clear level
      logic syncFound;    // Sync word detected pulse
      logic packetEnd;    // Packet ended pulse
      logic addrReject;   // Address filter discard pulse
      logic lenReject;    // Length filter discard pulse
      logic [7:0] pqValue;   // Measured preamble quality
      logic [7:0] pqThresh;  // Programmed threshold
      logic pqMeasured;   // Quality measurement valid
   } rsrb_radio_type;

   typedef struct packed {
      logic       crcMatch;
      logic       carrier;
      logic       pqReached;
      logic       chanClear;
      logic       frameStart;
      logic       pinTwo;
      logic       pinZero;
      logic [4:0] prevState;
      logic [7:0] rdData;
      logic [3:0] irqStatus;
      logic [3:0] irqMask;
   } rsrb_state_struct_type;

endpackage : rsrb_pkg

// file: rsrb_bank.sv
// Purpose: Status register bank of a sub-GHz packet radio; read-only except irq status and irq mask
// Assumes: Radio inputs share clk_sys; pin levels are asynchronous and synchronised here
// Notes:   Read data stand one cycle after the read strobe
// Notes on behaviour
// R1 - CRC-match bit 7 set on passing check, cleared entering or restarting receive
// R2 - Carrier indication in bit 6, cleared on entering idle
// R3 - Preamble-quality bit held after leaving receive until receive state re-entered
// R4 - Preamble-quality bit cleared when measured quality below threshold
// R5 - Frame-start bit 3 rises on sync detection, falls at packet end
// R6 - Frame-start also falls on address reject, length reject, receive overflow
// R7 - Frame-start reads zero while transmitting
// R8 - Bit 2 shows pin two level before output inversion
// R9 - Bit 0 shows pin zero level before output inversion
// R10 - Host avoids lock polling through pin bits when select is lock indicator
// R11 - Transmit count in bits 6:0, underflow flag in bit 7
// R12 - Receive count in bits 6:0, overflow flag in bit 7
// R13 - RC calibration results in bits 6:0, bit 7 reads zero
// R14 - VCO calibration DAC setting exposed in bits 7:0
// R15 - All registers read-only, writes ignored, reads have no side effect; the code takes writes to irq status (write one clears) and irq mask
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module rsrb_bank
   import rsrb_pkg::*;
#(
   parameter int CountW = 7
) (
   input  wire logic                      clk_sys,     // System clock 20 MHz
   input  wire logic                      rst_n,       // Synchronous reset, low
   input  wire logic                      clkEn,       // Freezes state while low
   input  wire logic [`RSRB_ADDR_W-1:0]   regAddr,     // Register address
   input  wire logic [7:0]                regWrData,   // Write data
   input  wire logic                      regWr,       // Write strobe
   input  wire logic                      regRd,       // Read strobe
   output logic      [7:0]                regRdData,   // Read data, cycle after strobe
   output logic                           irq,         // Level interrupt
   input  wire logic [4:0]                radioState,  // Radio control state code
   input  wire rsrb_radio_type            radio,       // Radio events and levels
   input  wire logic                      pinTwoRaw,   // Pin two level before inversion
   input  wire logic                      pinZeroRaw,  // Pin zero level before inversion
   input  wire logic [7:0]                vcoDac,      // VCO calibration DAC setting
   input  wire logic [CountW-1:0]         txCount,     // Transmit buffer bytes
   input  wire logic                      txUnder,     // Transmit underflow flag
   input  wire logic [CountW-1:0]         rxCount,     // Receive buffer bytes
   input  wire logic                      rxOver,      // Receive overflow flag
   input  wire logic [6:0]                rcHigh,      // RC calibration result high
   input  wire logic [6:0]                rcLow        // RC calibration result low
);

   ////////////////////////////////////////////////////////////////////////////
   rsrb_state_struct_type stateFf;
   rsrb_state_struct_type nxtState;
   logic [1:0] pinTwoSyncFf;
   logic [1:0] pinZeroSyncFf;

   // Two-stage synchronisers; logic reads only the second stage
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pinTwoSyncFf  <= 2'h0;
         pinZeroSyncFf <= 2'h0;
      end else if (clkEn) begin
         pinTwoSyncFf  <= {pinTwoSyncFf[0], pinTwoRaw};
         pinZeroSyncFf <= {pinZeroSyncFf[0], pinZeroRaw};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic enterRx;
   logic inTx;
   logic inRx;
   logic [3:0] events;
   logic [7:0] pktByte;

   assign enterRx = (radioState == `RSRB_STATE_RX || radioState == RSRB_ST_RX_RST)
                    && stateFf.prevState != radioState;
   assign inTx = radioState == RSRB_ST_TX || radioState == RSRB_ST_TX_END
                 || radioState == RSRB_ST_TX_UNDER;
   assign inRx = radioState == `RSRB_STATE_RX || radioState == RSRB_ST_RX_END;

   always_comb begin
      pktByte = 8'h00;
      pktByte[`RSRB_BIT_CRC_MATCH]   = stateFf.crcMatch;
      pktByte[`RSRB_BIT_CARRIER]     = stateFf.carrier;
      pktByte[`RSRB_BIT_PQ_REACHED]  = stateFf.pqReached;
      pktByte[`RSRB_BIT_CHAN_CLEAR]  = stateFf.chanClear;
      pktByte[`RSRB_BIT_FRAME_START] = stateFf.frameStart & ~inTx;  // see R7
      pktByte[`RSRB_BIT_PIN_TWO]     = stateFf.pinTwo;              // see R8
      pktByte[`RSRB_BIT_PIN_ZERO]    = stateFf.pinZero;             // see R9
   end

   always_comb begin
      events = 4'h0;
      events[`RSRB_IRQ_CRC]      = radio.crcDone & radio.crcPass;
      events[`RSRB_IRQ_FRAME]    = radio.syncFound & inRx;
      events[`RSRB_IRQ_TX_UNDER] = txUnder;
      events[`RSRB_IRQ_RX_OVER]  = rxOver;
   end

   always_comb begin
      nxtState = stateFf;
      nxtState.prevState = radioState;
      // CRC match: clear on receive entry, else latest check
      if (enterRx) begin
         nxtState.crcMatch = 1'b0;                                  // see R1
      end else if (radio.crcDone) begin
         nxtState.crcMatch = radio.crcPass;                         // see R1
      end
      // Carrier sense follows radio, forced low in idle
      nxtState.carrier = (radioState == RSRB_ST_IDLE) ? 1'b0 : radio.carrierSense;  // see R2
      nxtState.chanClear = radio.chanClear;
      // Preamble quality: set only in receive, cleared by a below-threshold measurement or on receive entry
      if (radio.pqMeasured && radio.pqValue < radio.pqThresh) begin
         nxtState.pqReached = 1'b0;                                 // see R4
      end else if (enterRx && radioState == `RSRB_STATE_RX) begin
         nxtState.pqReached = 1'b0;                                 // see R3
      end else if (inRx && radio.pqMeasured) begin
         nxtState.pqReached = 1'b1;
      end
      // Frame start delimiter
      if (radio.packetEnd || radio.addrReject || radio.lenReject
          || radioState == RSRB_ST_RX_OVER || !inRx) begin
         nxtState.frameStart = 1'b0;                                // see R5, R6
      end else if (radio.syncFound) begin
         nxtState.frameStart = 1'b1;                                // see R5
      end
      nxtState.pinTwo  = pinTwoSyncFf[1];
      nxtState.pinZero = pinZeroSyncFf[1];
      // Read mux; reads change no flag
      nxtState.rdData = 8'h00;
      if (regRd) begin
         case (regAddr)
            `RSRB_OFF_PKT_STATUS: nxtState.rdData = pktByte;
            `RSRB_OFF_VCO_DAC:    nxtState.rdData = vcoDac;                              // see R14
            `RSRB_OFF_TX_COUNT:   nxtState.rdData = {txUnder, txCount};                  // see R11
            `RSRB_OFF_RX_COUNT:   nxtState.rdData = {rxOver, rxCount};                   // see R12
            `RSRB_OFF_RC_HIGH:    nxtState.rdData = {1'b0, rcHigh};                      // see R13
            `RSRB_OFF_RC_LOW:     nxtState.rdData = {1'b0, rcLow};                       // see R13
            `RSRB_OFF_IRQ_STATUS: nxtState.rdData = {4'h0, stateFf.irqStatus};
            `RSRB_OFF_IRQ_MASK:   nxtState.rdData = {4'h0, stateFf.irqMask};
            default:              nxtState.rdData = 8'h00;
         endcase
      end
      // Interrupt registers: status write one clears, set wins; mask takes plain writes
      if (regWr && regAddr == `RSRB_OFF_IRQ_STATUS) begin
         nxtState.irqStatus = stateFf.irqStatus & ~regWrData[3:0];
      end
      if (regWr && regAddr == `RSRB_OFF_IRQ_MASK) begin
         nxtState.irqMask = regWrData[3:0];
      end
      nxtState.irqStatus = nxtState.irqStatus | events;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         stateFf <= '0;
      end else if (clkEn) begin
         stateFf <= nxtState;
      end
   end

   assign regRdData = stateFf.rdData;
   assign irq       = |(stateFf.irqStatus & stateFf.irqMask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   AST_CRC_CLEAR: assert property (clkEn && enterRx && !radio.crcDone |=> !stateFf.crcMatch)  // see R1
      else $error("crc match not cleared on receive entry");
   AST_CARRIER_IDLE: assert property (clkEn && radioState == RSRB_ST_IDLE |=> !stateFf.carrier)  // see R2
      else $error("carrier not cleared in idle");
   AST_PQ_HOLD: assert property (clkEn && stateFf.pqReached && !inRx && !radio.pqMeasured
                                 |=> stateFf.pqReached)  // see R3
      else $error("preamble quality bit dropped outside receive");
   AST_PQ_LOW: assert property (clkEn && radio.pqMeasured && radio.pqValue < radio.pqThresh
                                |=> !stateFf.pqReached)  // see R4
      else $error("preamble quality bit kept below threshold");
   AST_SFD_SET: assert property (clkEn && inRx && radio.syncFound && !radio.packetEnd && !radio.addrReject
                                 && !radio.lenReject |=> stateFf.frameStart)  // see R5
      else $error("frame start not raised on sync");
   AST_SFD_DROP: assert property (clkEn && (radio.addrReject || radio.lenReject || radio.packetEnd)
                                  |=> !stateFf.frameStart)  // see R6
      else $error("frame start not dropped");
   AST_SFD_TX: assert property (clkEn && regRd && regAddr == `RSRB_OFF_PKT_STATUS && inTx
                                |=> !regRdData[`RSRB_BIT_FRAME_START])  // see R7
      else $error("frame start read high in transmit");
   AST_PIN_TWO: assert property (clkEn && regRd && regAddr == `RSRB_OFF_PKT_STATUS
                                 |=> regRdData[`RSRB_BIT_PIN_TWO] == $past(stateFf.pinTwo))  // see R8
      else $error("pin two bit wrong");
   AST_TX_COUNT: assert property (clkEn && regRd && regAddr == `RSRB_OFF_TX_COUNT
                                  |=> regRdData == {$past(txUnder), $past(txCount)})  // see R11
      else $error("transmit count read wrong");
   AST_RC_TOP: assert property (clkEn && regRd && (regAddr == `RSRB_OFF_RC_HIGH || regAddr == `RSRB_OFF_RC_LOW)
                                |=> !regRdData[7])  // see R13
      else $error("rc result bit 7 not zero");
   AST_NO_READ: assert property (clkEn && !regRd |=> regRdData == 8'h00)  // see R15
      else $error("read data without strobe");
   AST_PIN_ZERO: assert property (clkEn && regRd && regAddr == `RSRB_OFF_PKT_STATUS
                                  |=> regRdData[`RSRB_BIT_PIN_ZERO] == $past(stateFf.pinZero))  // see R9
      else $error("pin zero bit wrong");
   AST_RX_COUNT: assert property (clkEn && regRd && regAddr == `RSRB_OFF_RX_COUNT
                                  |=> regRdData == {$past(rxOver), $past(rxCount)})  // see R12
      else $error("receive count read wrong");
   AST_VCO_DAC: assert property (clkEn && regRd && regAddr == `RSRB_OFF_VCO_DAC
                                 |=> regRdData == $past(vcoDac))  // see R14
      else $error("vco dac read wrong");
   AST_SFD_OVER: assert property (clkEn && radioState == RSRB_ST_RX_OVER
                                  |=> !stateFf.frameStart)  // see R6
      else $error("frame start kept in receive overflow");
   AST_RO_WRITE: assert property (clkEn && regWr && regAddr == `RSRB_OFF_PKT_STATUS && !regRd
                                  |=> regRdData == 8'h00)  // see R15
      else $error("write to status register produced read data");

   COV_SFD: cover property (clkEn && inRx && radio.syncFound ##[1:20] radio.packetEnd);
   COV_PQ_HOLD: cover property (stateFf.pqReached && !inRx);
   COV_IRQ: cover property (irq);
   COV_CRC: cover property (clkEn && radio.crcDone && radio.crcPass ##1 stateFf.crcMatch);

endmodule : rsrb_bank

// file: rsrb_host_model.sv
// Purpose: Host side of the register port, one byte per access
// Assumes: Strobes change by non-blocking assignment right after a rising edge
// Notes:   Read data are taken in the single cycle after the read strobe
`timescale 1ns/1ns
module rsrb_host_model (
   input  wire logic       clk_sys,   // System clock
   output logic [5:0]      regAddr,   // Register address
   output logic [7:0]      regWrData, // Write data
   output logic            regWr,     // Write strobe
   output logic            regRd,     // Read strobe
   input  wire logic [7:0] regRdData  // Read data
);
   initial begin
      regAddr = 6'h00;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end

   // Pin bits are taken as plain levels, never as a lock indication
   task automatic readReg(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : readReg

   task automatic writeReg(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask : writeReg
endmodule : rsrb_host_model

// file: test_radio_status_register_bank.sv
// Purpose: Self-checking bench of the radio status register bank
// Assumes: Host model issues all register accesses
// Notes:   Radio inputs change by non-blocking assignment after an edge
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin badCount++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module test_radio_status_register_bank;
   import rsrb_pkg::*;
   logic           clk_sys = 1'b0;
   logic           rst_n = 1'b0;
   logic [4:0]     radioState;
   rsrb_radio_type radio;
   logic           pinTwoRaw, pinZeroRaw, txUnder, rxOver, regWr, regRd, irq;
   logic [7:0]     vcoDac, regWrData, regRdData;
   logic [6:0]     txCount, rxCount, rcHigh, rcLow;
   logic [5:0]     regAddr;
   int             badCount = 0;
   int             cmpCount = 0;
   int             cycles = 0;

   always #25 clk_sys = ~clk_sys;

   rsrb_host_model rsrb_host_model_inst (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
   rsrb_bank #(.CountW(7)) rsrb_bank_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .irq(irq), .radioState(radioState), .radio(radio), .pinTwoRaw(pinTwoRaw), .pinZeroRaw(pinZeroRaw),
      .vcoDac(vcoDac), .txCount(txCount), .txUnder(txUnder), .rxCount(rxCount), .rxOver(rxOver),
      .rcHigh(rcHigh), .rcLow(rcLow));

   task automatic printVerdict();
      if (badCount == 0 && cmpCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : printVerdict

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic chk(input logic [5:0] a, input logic [7:0] ex, input string nm);
      logic [7:0] d;
      rsrb_host_model_inst.readReg(a, d);
      `CHK(nm, ex, d)
   endtask : chk

   // One-cycle radio event (k=3 leaves radioState at 5'h11), then time for the flag to settle
   task automatic pulse(input int k);
      case (k)
         0: radio.packetEnd <= 1'b1;
         1: radio.addrReject <= 1'b1;
         2: radio.lenReject <= 1'b1;
         3: radioState <= 5'h11;
         4: radio.syncFound <= 1'b1;
         default: radio.crcDone <= 1'b1;
      endcase
      tick(1);
      {radio.packetEnd, radio.addrReject, radio.lenReject, radio.syncFound, radio.crcDone} <= '0;
      tick(2);
   endtask : pulse

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         printVerdict();
      end
   end

   initial begin
      radioState = 5'h01; radio = '0; pinTwoRaw = 1'b0; pinZeroRaw = 1'b0; vcoDac = 8'ha5;
      txCount = 7'h15; txUnder = 1'b1; rxCount = 7'h7f; rxOver = 1'b0; rcHigh = 7'h7f; rcLow = 7'h2a;
      tick(8);
      rst_n <= 1'b1;
      chk(6'h38, 8'h00, "pktReset");
      for (int i = 0; i < 2; i++) begin
         chk(6'h39, 8'ha5, "vcoDac");
         chk(6'h3a, 8'h95, "txCount");
         chk(6'h3b, 8'h7f, "rxCount");
         chk(6'h3c, 8'h7f, "rcHigh");
         chk(6'h3d, 8'h2a, "rcLow");
         for (int a = 8'h38; a < 8'h3e; a++) rsrb_host_model_inst.writeReg(a[5:0], 8'hff);
      end
      chk(6'h38, 8'h00, "pktAfterWrite");
      chk(6'h00, 8'h00, "unmapped");
      `CHK("irqMasked", 1'b0, irq)
      txUnder <= 1'b0;
      tick(2);
      rsrb_host_model_inst.writeReg(6'h3e, 8'hff);
      rsrb_host_model_inst.writeReg(6'h3f, 8'h01);
      radioState <= 5'h0d;
      radio.crcPass <= 1'b1;
      tick(2);
      pulse(5);
      `CHK("irqRaised", 1'b1, irq)
      chk(6'h3e, 8'h01, "irqStatus");
      chk(6'h38, 8'h80, "crcSet");
      chk(6'h38, 8'h80, "crcReread");
      rsrb_host_model_inst.writeReg(6'h3e, 8'h01);
      tick(1);
      `CHK("irqCleared", 1'b0, irq)
      radioState <= 5'h0f;
      tick(2);
      chk(6'h38, 8'h00, "crcRestart");
      radioState <= 5'h0d;
      radio.carrierSense <= 1'b1;
      tick(2);
      chk(6'h38, 8'h40, "carrier");
      radioState <= 5'h01;
      tick(2);
      chk(6'h38, 8'h00, "carrierIdle");
      radio.carrierSense <= 1'b0;
      radioState <= 5'h0d;
      radio.pqThresh <= 8'h10;
      radio.pqValue <= 8'h20;
      radio.pqMeasured <= 1'b1;
      tick(2);
      radio.pqMeasured <= 1'b0;
      radioState <= 5'h13;
      tick(2);
      chk(6'h38, 8'h20, "pqHeld");
      radioState <= 5'h0d;
      tick(2);
      chk(6'h38, 8'h00, "pqReentry");
      radio.pqMeasured <= 1'b1;
      tick(2);
      chk(6'h38, 8'h20, "pqSet");
      radio.pqValue <= 8'h0f;
      tick(2);
      chk(6'h38, 8'h00, "pqBelow");
      radio.pqMeasured <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         radioState <= 5'h0d;
         pulse(4);
         chk(6'h38, 8'h08, "frameStart");
         pulse(k);
         chk(6'h38, 8'h00, "frameStop");
      end
      radioState <= 5'h0d;
      pulse(4);
      radioState <= 5'h13;
      tick(2);
      chk(6'h38, 8'h00, "frameInTx");
      radioState <= 5'h01;
      pinTwoRaw <= 1'b1;
      radio.chanClear <= 1'b1;
      tick(4);
      chk(6'h38, 8'h14, "pinTwo");
      pinTwoRaw <= 1'b0;
      pinZeroRaw <= 1'b1;
      tick(4);
      chk(6'h38, 8'h11, "pinZero");
      rxOver <= 1'b1;
      tick(1);
      chk(6'h3b, 8'hff, "rxOverflow");
      printVerdict();
   end
endmodule : test_radio_status_register_bank
